// >>> logic/adm_pkg.sv
// constants and types for the adc diagnostics monitor
package adm_pkg;
    // register addresses
    localparam logic [6:0] STATUS_ADDR = 7'h01;
    localparam logic [6:0] CLKCNT_ADDR = 7'h02;
    localparam logic [6:0] CFG3_ADDR = 7'h03;
    localparam logic [6:0] MAP_CRC_HI_ADDR = 7'h05;
    localparam logic [6:0] MAP_CRC_LO_ADDR = 7'h06;
    localparam logic [6:0] MAP_FIRST_ADDR = 7'h08;
    localparam logic [6:0] DPCFG1_ADDR = 7'h10;
    localparam logic [6:0] MAX_ADDR = 7'h50;
    localparam int MEM_DEPTH = 81;
    // error_flags bit positions
    localparam int ST_ALV = 6;
    localparam int ST_POR = 5;
    localparam int ST_SPI = 4;
    localparam int ST_REG = 3;
    localparam int ST_ADC = 2;
    localparam int ST_ADDR = 1;
    localparam int ST_SCLK = 0;
    localparam logic [6:0] STATUS_RESET = 7'h60;
    localparam logic [6:0] STATUS_W1C_MASK = 7'h7B;
    // general_config_three bit positions
    localparam int CFG3_STAT_OUT = 5;
    localparam int CFG3_SPI_CRC = 4;
    localparam int CFG3_REG_CRC = 3;
    localparam int CFG3_ADDR_EN = 2;
    localparam int CFG3_BITCNT = 1;
    localparam int CFG3_CLKCNT = 0;
    // data_port_config_one bit positions
    localparam int DP_HDR_EN = 7;
    localparam int PACKET_CRC_ENABLE = 6;
    // crc engines
    localparam logic [7:0] CRC8_POLY = 8'h07;
    localparam logic [7:0] CRC8_INIT = 8'hFF;
    localparam logic [15:0] CRC16_POLY = 16'h8005;
    localparam logic [15:0] CRC16_INIT = 16'hFFFF;
    // clock counter prescaler, divide by 32
    localparam int CLK_DIV = 32;
    localparam logic [4:0] PRESC_LAST = 5'(CLK_DIV - 1);
    localparam logic [7:0] RESET_BYTE = 8'h00;
    typedef enum logic [1:0] {
        WK_SCAN = 2'b01,
        WK_CHECK = 2'b10
    } adm_walk_t;
endpackage : adm_pkg

// >>> logic/adm_crc8_byte.sv
// one byte step of the crc-8 engine, msb first
`timescale 1ns/10ps
module adm_crc8_byte
    import adm_pkg::*;
(
    input wire logic [7:0] crc_in, // running remainder
    input wire logic [7:0] data_in, // byte to fold in
    output logic [7:0] crc_out // updated remainder
);
    always_comb begin
        logic [7:0] c;
        c = crc_in;
        for (int i = 7; i >= 0; i--) begin
            if (c[7] ^ data_in[i]) begin // RULE11 RULE24
                c = {c[6:0], 1'b0} ^ CRC8_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        crc_out = c;
    end
endmodule : adm_crc8_byte

// >>> logic/adm_monitor.sv
// diagnostics monitor: error flags, spi crc, map crc, counters, packet crc
//
// Contract
// RULE1 - open-drain low-active error pin asserts on OR of the seven flags.
// RULE2 - flag bits: alv 6, por 5, spi 4, reg 3, adc 2, addr 1, sclk 0.
// RULE3 - analog low-voltage and power-on flags are set by reset.
// RULE4 - writing one to a flag bit clears it; host clears after cause goes.
// RULE5 - header error bit is the inverse of the error pin level; the code holds it at zero in hardware mode.
// RULE6 - in hardware mode only the converter error drives the error pin.
// RULE7 - input crc covers only the two command bytes, not leading padding.
// RULE8 - bad input crc drops command, sets flag, blocks non-status writes.
// RULE9 - reads run unless the previous read frame had a crc error.
// RULE10 - output crc covers read data and status byte, zero if disabled.
// RULE11 - crc-8 polynomial x8+x2+x+1 with initial all-ones on first byte.
// RULE12 - spi crc check and output only while spi crc enable is set.
// RULE13 - host stores map crc at 05h/06h; device recomputes over 08h-50h.
// RULE14 - map crc polynomial x16+x15+x2+1, checked only when enabled.
// RULE15 - memory fault sets converter error, cleared only by reset.
// RULE16 - access above 50h sets address error; then non-status writes block.
// RULE17 - frame bit count not multiple of eight sets flag, blocks writes.
// RULE18 - clock counter is 8 bits, wraps, steps at clock divided by 32.
// RULE19 - clock counter starts at zero when enabled, reads zero when off.
// RULE20 - host reads clock counter only while converting, fast enough sclk.
// RULE21 - packet crc byte over two data bytes plus header when enabled.
// RULE22 - header power bit is the OR of alv and por flags; the code holds it at zero in hardware mode.
// RULE23 - header enable is bit 7, packet crc enable bit 6 of dp config.
// RULE24 - crc engines take bits msb first, bytes in transmit order.
`timescale 1ns/10ps
module adm_monitor
    import adm_pkg::*;
(
    input wire logic CLK_SYS_IN, // system clock, 40 mhz
    input wire logic RSTN_IN, // synchronous reset, low active
    input wire logic CE_IN, // clock enable, freezes state when low
    input wire logic HW_MODE_IN, // pin-programmed hardware mode
    input wire logic ANALOG_LOW_IN, // analog supply low level
    input wire logic NVM_FAULT_IN, // internal memory check fault
    input wire logic SPI_CS_N_IN, // spi chip select, low active
    input wire logic SPI_BIT_STB_IN, // one pulse per sclk rising edge
    input wire logic SPI_MOSI_IN, // sampled mosi bit
    output logic RESP_VALID_OUT, // pulse: response bytes updated
    output logic [7:0] RESP_DATA_OUT, // read register data
    output logic [7:0] RESP_STATUS_OUT, // status byte or zero
    output logic [7:0] RESP_CRC_OUT, // output crc, zero when disabled
    input wire logic ERROR_N_IN, // level seen on error wire
    output logic ERROR_N_OUT, // error pin drive value, always low
    output logic ERROR_N_OE_OUT, // error pin pulls low while high
    input wire logic PKT_STB_IN, // pulse: new channel packet
    input wire logic [15:0] PKT_DATA_IN, // channel conversion data
    input wire logic [5:0] PKT_FLAGS_IN, // header bits 5 down to 0
    output logic PKT_VALID_OUT, // pulse: packet bytes updated
    output logic [7:0] PKT_HEADER_OUT, // data_port_header byte
    output logic [7:0] PKT_CRC_OUT, // packet crc byte
    output logic PKT_HDR_EN_OUT, // packet_header_enable
    output logic PKT_CRC_EN_OUT // packet_crc_enable
);
    logic [7:0] mem_q [0:MEM_DEPTH-1];
    logic [6:0] flags_q;
    logic [6:0] flags_d;
    logic cs_n_q;
    logic [7:0] shift_q;
    logic [2:0] bit_cnt_q;
    logic [1:0] byte_cnt_q;
    logic [7:0] b0_q, b1_q, b2_q;
    logic rd_block_q;
    logic [4:0] presc_q;
    logic [7:0] clock_check_counter_q;
    adm_walk_t walk_q;
    logic [6:0] walk_addr_q;
    logic [15:0] map_crc_q;
    logic err_q;

    logic [7:0] general_config_three;
    logic [7:0] data_port_config_one;
    logic spi_crc_en, reg_crc_en, addr_chk_en;
    logic frame_bit_count_enable, clock_check_enable, status_out_en;
    logic packet_header_enable, packet_crc_enable;
    assign general_config_three = mem_q[CFG3_ADDR];
    assign data_port_config_one = mem_q[DPCFG1_ADDR];
    assign status_out_en = general_config_three[CFG3_STAT_OUT];
    assign spi_crc_en = general_config_three[CFG3_SPI_CRC];
    assign reg_crc_en = general_config_three[CFG3_REG_CRC];
    assign addr_chk_en = general_config_three[CFG3_ADDR_EN];
    assign frame_bit_count_enable = general_config_three[CFG3_BITCNT];
    assign clock_check_enable = general_config_three[CFG3_CLKCNT];
    assign packet_header_enable = data_port_config_one[DP_HDR_EN]; // RULE23
    assign packet_crc_enable = data_port_config_one[PACKET_CRC_ENABLE]; // RULE23

    // frame decode, evaluated on chip select release
    logic frame_end, frame_begin;
    logic [7:0] cmd0, cmd1, crc_in_calc, crc_mid;
    logic [6:0] addr;
    logic is_read, crc_ok, nb_ok, sclk_bad, addr_bad, go;
    logic wr_block, do_wr, do_rd;
    assign frame_end = SPI_CS_N_IN & ~cs_n_q & ~HW_MODE_IN;
    assign frame_begin = ~SPI_CS_N_IN & cs_n_q;
    // last bytes are the command, so padding ahead of it is skipped
    assign cmd0 = spi_crc_en ? b2_q : b1_q; // RULE7
    assign cmd1 = spi_crc_en ? b1_q : b0_q; // RULE7
    assign is_read = cmd0[7];
    assign addr = cmd0[6:0];
    assign nb_ok = spi_crc_en ? (byte_cnt_q == 2'd3) : (byte_cnt_q >= 2'd2);
    assign crc_ok = ~spi_crc_en | (crc_in_calc == b0_q); // RULE12
    assign sclk_bad = frame_bit_count_enable & (bit_cnt_q != 3'd0); // RULE17
    assign addr_bad = addr_chk_en & (addr > MAX_ADDR); // RULE16
    assign go = frame_end & nb_ok & ~sclk_bad;
    assign wr_block = (flags_q[ST_SPI] | flags_q[ST_ADDR] | flags_q[ST_SCLK])
        & (addr != STATUS_ADDR); // RULE8 RULE16 RULE17
    assign do_wr = go & crc_ok & ~is_read & ~addr_bad & ~wr_block
        & (addr <= MAX_ADDR); // RULE8
    assign do_rd = go & crc_ok & is_read & ~rd_block_q
        & (addr <= MAX_ADDR); // RULE9

    adm_crc8_byte u_crc_cmd0 (
        .crc_in(CRC8_INIT),
        .data_in(cmd0),
        .crc_out(crc_mid)
    );
    adm_crc8_byte u_crc_cmd1 (
        .crc_in(crc_mid),
        .data_in(cmd1),
        .crc_out(crc_in_calc)
    );

    // read data and output crc
    logic [7:0] rd_data, stat_byte, out_mid, out_crc;
    always_comb begin
        if (addr == STATUS_ADDR) begin
            rd_data = {1'b0, flags_q};
        end else if (addr == CLKCNT_ADDR) begin
            rd_data = clock_check_counter_q;
        end else if (addr <= MAX_ADDR) begin
            rd_data = mem_q[addr];
        end else begin
            rd_data = RESET_BYTE;
        end
    end
    assign stat_byte = status_out_en ? {1'b0, flags_q} : RESET_BYTE; // RULE10
    adm_crc8_byte u_crc_out0 (
        .crc_in(CRC8_INIT),
        .data_in(rd_data),
        .crc_out(out_mid)
    );
    adm_crc8_byte u_crc_out1 (
        .crc_in(out_mid),
        .data_in(stat_byte),
        .crc_out(out_crc)
    );

    // bit and byte assembly
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RSTN_IN) begin
            cs_n_q <= 1'b1;
            shift_q <= RESET_BYTE;
            bit_cnt_q <= 3'd0;
            byte_cnt_q <= 2'd0;
            b0_q <= RESET_BYTE;
            b1_q <= RESET_BYTE;
            b2_q <= RESET_BYTE;
        end else if (CE_IN) begin
            cs_n_q <= SPI_CS_N_IN;
            if (frame_begin) begin
                bit_cnt_q <= 3'd0;
                byte_cnt_q <= 2'd0;
            end else if (!SPI_CS_N_IN && SPI_BIT_STB_IN) begin
                shift_q <= {shift_q[6:0], SPI_MOSI_IN}; // RULE24
                bit_cnt_q <= bit_cnt_q + 3'd1;
                if (bit_cnt_q == 3'd7) begin
                    b0_q <= {shift_q[6:0], SPI_MOSI_IN};
                    b1_q <= b0_q;
                    b2_q <= b1_q;
                    if (byte_cnt_q != 2'd3) begin
                        byte_cnt_q <= byte_cnt_q + 2'd1;
                    end
                end
            end
        end
    end

    // register array writes
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RSTN_IN) begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem_q[i] <= RESET_BYTE;
            end
        end else if (CE_IN) begin
            if (do_wr && addr != STATUS_ADDR && addr != CLKCNT_ADDR) begin
                mem_q[addr] <= cmd1;
            end
        end
    end

    // read blocking follows the crc outcome of the last read frame
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RSTN_IN) begin
            rd_block_q <= 1'b0;
        end else if (CE_IN) begin
            if (go && is_read) begin
                rd_block_q <= ~crc_ok; // RULE9
            end
        end
    end

    // response bytes
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RSTN_IN) begin
            RESP_VALID_OUT <= 1'b0;
            RESP_DATA_OUT <= RESET_BYTE;
            RESP_STATUS_OUT <= RESET_BYTE;
            RESP_CRC_OUT <= RESET_BYTE;
        end else if (CE_IN) begin
            RESP_VALID_OUT <= do_rd;
            if (do_rd) begin
                RESP_DATA_OUT <= rd_data;
                RESP_STATUS_OUT <= stat_byte;
                RESP_CRC_OUT <= spi_crc_en ? out_crc : RESET_BYTE; // RULE12
            end
        end
    end

    // sticky error flags, a set wins over a clear in the same cycle
    logic map_mismatch;
    always_comb begin
        logic [6:0] set_v;
        logic [6:0] clr_v;
        set_v = '0;
        clr_v = '0;
        set_v[ST_ALV] = ANALOG_LOW_IN;
        set_v[ST_SPI] = go & ~crc_ok; // RULE8
        set_v[ST_REG] = map_mismatch; // RULE13
        set_v[ST_ADC] = NVM_FAULT_IN; // RULE15
        set_v[ST_ADDR] = go & crc_ok & addr_bad; // RULE16
        set_v[ST_SCLK] = frame_end & sclk_bad; // RULE17
        if (do_wr && addr == STATUS_ADDR) begin
            clr_v = cmd1[6:0] & STATUS_W1C_MASK; // RULE4 RULE15
        end
        flags_d = (flags_q & ~clr_v) | set_v; // RULE4
    end
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RSTN_IN) begin
            flags_q <= STATUS_RESET; // RULE2 RULE3
        end else if (CE_IN) begin
            flags_q <= flags_d;
        end
    end

    // error pin, only the converter error counts in hardware mode
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RSTN_IN) begin
            err_q <= 1'b1;
        end else if (CE_IN) begin
            err_q <= HW_MODE_IN ? flags_q[ST_ADC] : |flags_q; // RULE1 RULE6
        end
    end
    assign ERROR_N_OUT = 1'b0;
    assign ERROR_N_OE_OUT = err_q; // RULE1

    // clock check counter
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RSTN_IN) begin
            presc_q <= 5'd0;
            clock_check_counter_q <= RESET_BYTE;
        end else if (CE_IN) begin
            if (!clock_check_enable) begin
                presc_q <= 5'd0; // RULE19
                clock_check_counter_q <= RESET_BYTE; // RULE19
            end else begin
                presc_q <= presc_q + 5'd1;
                if (presc_q == PRESC_LAST) begin
                    clock_check_counter_q <= clock_check_counter_q + 8'd1;
                end // RULE18
            end
        end
    end

    // register map crc walker over 08h to 50h
    function automatic logic [15:0] crc16_step(input logic [15:0] c_in,
                                               input logic [7:0] d);
        logic [15:0] c;
        c = c_in;
        for (int i = 7; i >= 0; i--) begin
            if (c[15] ^ d[i]) begin // RULE14 RULE24
                c = {c[14:0], 1'b0} ^ CRC16_POLY;
            end else begin
                c = {c[14:0], 1'b0};
            end
        end
        return c;
    endfunction : crc16_step

    assign map_mismatch = (walk_q == WK_CHECK) & reg_crc_en & ~do_wr
        & (map_crc_q != {mem_q[MAP_CRC_HI_ADDR], mem_q[MAP_CRC_LO_ADDR]});
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RSTN_IN) begin
            walk_q <= WK_SCAN;
            walk_addr_q <= MAP_FIRST_ADDR;
            map_crc_q <= CRC16_INIT;
        end else if (CE_IN) begin
            if (do_wr) begin
                walk_q <= WK_SCAN; // restart after any change
                walk_addr_q <= MAP_FIRST_ADDR;
                map_crc_q <= CRC16_INIT;
            end else begin
                case (walk_q)
                    WK_SCAN: begin
                        map_crc_q <= crc16_step(map_crc_q,
                                                mem_q[walk_addr_q]); // RULE13
                        if (walk_addr_q == MAX_ADDR) begin
                            walk_q <= WK_CHECK;
                        end else begin
                            walk_addr_q <= walk_addr_q + 7'd1;
                        end
                    end
                    WK_CHECK: begin
                        walk_q <= WK_SCAN;
                        walk_addr_q <= MAP_FIRST_ADDR;
                        map_crc_q <= CRC16_INIT;
                    end
                    default: begin
                        walk_q <= WK_SCAN;
                        walk_addr_q <= MAP_FIRST_ADDR;
                        map_crc_q <= CRC16_INIT;
                    end
                endcase
            end
        end
    end

    // data-port packet header and crc
    logic [7:0] hdr, pk_a, pk_b_in, pk_b, pk_c;
    assign hdr = {~HW_MODE_IN & (flags_q[ST_ALV] | flags_q[ST_POR]), // RULE22
                  ~HW_MODE_IN & ~ERROR_N_IN, // RULE5
                  PKT_FLAGS_IN};
    adm_crc8_byte u_crc_hdr (
        .crc_in(CRC8_INIT),
        .data_in(hdr),
        .crc_out(pk_a)
    );
    assign pk_b_in = packet_header_enable ? pk_a : CRC8_INIT; // RULE21
    adm_crc8_byte u_crc_dhi (
        .crc_in(pk_b_in),
        .data_in(PKT_DATA_IN[15:8]),
        .crc_out(pk_b)
    );
    adm_crc8_byte u_crc_dlo (
        .crc_in(pk_b),
        .data_in(PKT_DATA_IN[7:0]),
        .crc_out(pk_c)
    );
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RSTN_IN) begin
            PKT_VALID_OUT <= 1'b0;
            PKT_HEADER_OUT <= RESET_BYTE;
            PKT_CRC_OUT <= RESET_BYTE;
            PKT_HDR_EN_OUT <= 1'b0;
            PKT_CRC_EN_OUT <= 1'b0;
        end else if (CE_IN) begin
            PKT_VALID_OUT <= PKT_STB_IN;
            PKT_HDR_EN_OUT <= packet_header_enable;
            PKT_CRC_EN_OUT <= packet_crc_enable;
            if (PKT_STB_IN) begin
                PKT_HEADER_OUT <= hdr;
                PKT_CRC_OUT <= packet_crc_enable ? pk_c : RESET_BYTE; // RULE21
            end
        end
    end

    // checks
    pin_or_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
        CE_IN && !HW_MODE_IN |=> ERROR_N_OE_OUT == |$past(flags_q)) // RULE1
        else $error("error pin not OR of flags");
    hw_mode_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
        CE_IN && HW_MODE_IN
        |=> ERROR_N_OE_OUT == $past(flags_q[ST_ADC])) // RULE6
        else $error("hardware mode error pin wrong");
    por_flags_a: assert property (@(posedge CLK_SYS_IN)
        !RSTN_IN |=> flags_q[ST_ALV] && flags_q[ST_POR] && ERROR_N_OE_OUT) // RULE3
        else $error("power flags not set by reset");
    adc_sticky_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
        flags_q[ST_ADC] |=> flags_q[ST_ADC]) // RULE15
        else $error("converter error cleared without reset");
    crc_drop_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
        CE_IN && go && !crc_ok
        |-> !do_wr && !do_rd ##1 flags_q[ST_SPI]) // RULE8
        else $error("bad crc command executed or not flagged");
    wr_block_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
        (flags_q[ST_ADDR] || flags_q[ST_SCLK]) && addr != STATUS_ADDR
        |-> !do_wr) // RULE16 RULE17
        else $error("write passed while blocked");
    w1c_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
        CE_IN && do_wr && addr == STATUS_ADDR && cmd1[ST_POR]
        |=> !flags_q[ST_POR]) // RULE4
        else $error("status write one did not clear");
    cnt_off_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
        CE_IN && !clock_check_enable
        |=> clock_check_counter_q == 8'h00) // RULE19
        else $error("clock counter not zero while off");
    cnt_rate_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
        CE_IN && clock_check_enable && presc_q != PRESC_LAST
        && !(do_wr && addr == CFG3_ADDR)
        |=> $stable(clock_check_counter_q)) // RULE18
        else $error("clock counter stepped early");
    hdr_bits_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
        CE_IN && PKT_STB_IN && !HW_MODE_IN |=> PKT_HEADER_OUT[6]
        == !$past(ERROR_N_IN) && PKT_HEADER_OUT[7]
        == $past(flags_q[ST_ALV] | flags_q[ST_POR])) // RULE5 RULE22
        else $error("header power or error bit wrong");
    bitcnt_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
        CE_IN && frame_end && sclk_bad |=> flags_q[ST_SCLK]) // RULE17
        else $error("bit count error not flagged");
endmodule : adm_monitor

// >>> bench/adm_host_model.sv
// host controller model: spi bit stream and pulled-up error wire
`timescale 1ns/10ps
module adm_host_model (
    input wire logic clk_in, // system clock
    input wire logic oe_in, // device pulls the wire low
    output logic err_n_out, // wire level seen by all
    output logic cs_n_out, // frame select, low active
    output logic stb_out, // one pulse per serial bit
    output logic mosi_out // serial data bit
);
    assign err_n_out = oe_in ? 1'b0 : 1'b1;
    initial begin
        cs_n_out = 1'b1;
        stb_out = 1'b0;
        mosi_out = 1'b0;
    end
    // sends the top n bits, msb first
    task automatic send(input logic [31:0] v, input int n);
        @(negedge clk_in) cs_n_out = 1'b0;
        for (int i = 0; i < n; i++) begin
            @(negedge clk_in) mosi_out = v[31 - i];
            stb_out = 1'b1;
            @(negedge clk_in) stb_out = 1'b0;
        end
        @(negedge clk_in) cs_n_out = 1'b1;
        mosi_out = ~mosi_out;
    endtask : send
endmodule : adm_host_model

// >>> bench/adm_monitor_tb.sv
// self-checking bench for the diagnostics monitor
`timescale 1ns/10ps
module adm_monitor_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic nvm = 1'b0;
    logic pstb = 1'b0;
    logic crc_on = 1'b0;
    logic [15:0] pdat = 16'h0000;
    logic [5:0] pflg = 6'h00;
    logic [15:0] seed = 16'h0039;
    logic oe, errw, cs_n, stb, mosi, rd_v, rv, pv, hen, cen;
    logic [7:0] rd_d, rd_s, rd_c, rdat, rst, rcrc, phdr, pcrc;
    int n_mismatch = 0;
    int num_checks = 0;
    always #12.5 clk = ~clk;
    adm_host_model host (.clk_in(clk), .oe_in(oe), .err_n_out(errw),
        .cs_n_out(cs_n), .stb_out(stb), .mosi_out(mosi));
    adm_monitor dut (.CLK_SYS_IN(clk), .RSTN_IN(rstn), .CE_IN(1'b1),
        .HW_MODE_IN(1'b0), .ANALOG_LOW_IN(1'b0), .NVM_FAULT_IN(nvm),
        .SPI_CS_N_IN(cs_n), .SPI_BIT_STB_IN(stb), .SPI_MOSI_IN(mosi),
        .RESP_VALID_OUT(rd_v), .RESP_DATA_OUT(rd_d),
        .RESP_STATUS_OUT(rd_s), .RESP_CRC_OUT(rd_c), .ERROR_N_IN(errw),
        .ERROR_N_OUT(), .ERROR_N_OE_OUT(oe), .PKT_STB_IN(pstb),
        .PKT_DATA_IN(pdat), .PKT_FLAGS_IN(pflg), .PKT_VALID_OUT(pv),
        .PKT_HEADER_OUT(phdr), .PKT_CRC_OUT(pcrc),
        .PKT_HDR_EN_OUT(hen), .PKT_CRC_EN_OUT(cen));
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr
    function automatic logic [7:0] crc8(input logic [23:0] v, input int nb);
        logic [7:0] c;
        c = 8'hFF;
        for (int i = nb - 1; i >= 0; i--) begin
            c ^= v[i*8 +: 8];
            for (int b = 0; b < 8; b++) begin
                c = {c[6:0], 1'b0} ^ (c[7] ? 8'h07 : 8'h00);
            end
        end
        return c;
    endfunction : crc8
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic final_report;
        if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report
    task automatic xfer(input logic r, input logic [6:0] a,
        input logic [7:0] d, input logic bad, input logic pad);
        logic [31:0] v;
        int n;
        v = {r, a, d, crc8({8'h00, r, a, d}, 2) ^ {7'h00, bad}, 8'h00};
        n = crc_on ? 24 : 16;
        if (pad) begin
            v = {8'hA5, v[31:8]};
            n += 8;
        end
        host.send(v, n);
        rv = 1'b0;
        repeat (4) @(negedge clk) if (rd_v === 1'b1) begin
            rv = 1'b1;
            rdat = rd_d;
            rst = rd_s;
            rcrc = rd_c;
        end
    endtask : xfer
    task automatic pkt(input logic hd, input logic cr, input logic [1:0] pe);
        logic [7:0] h;
        logic [7:0] c;
        @(negedge clk) pstb = 1'b1;
        pdat = seed;
        pflg = seed[5:0];
        seed = lfsr(seed);
        @(negedge clk) pstb = 1'b0;
        h = {pe, pflg};
        c = hd ? crc8({h, pdat}, 3) : crc8({8'h00, pdat}, 2);
        chk(pv, 1'b1);
        chk(phdr, h);
        chk({hen, cen}, {hd, cr});
        chk(pcrc, cr ? c : 8'h00);
    endtask : pkt
    initial begin
        #500000;
        n_mismatch++;
        final_report;
    end
    initial begin
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        xfer(1, 7'h01, 8'h00, 0, 0);
        chk(rdat, 8'h60);
        chk(rcrc, 8'h00);
        chk(oe, 1'b1);
        xfer(0, 7'h10, 8'hC0, 0, 0);
        pkt(1, 1, 2'b11);
        xfer(0, 7'h01, 8'h7F, 0, 0);
        xfer(1, 7'h01, 8'h00, 0, 0);
        chk(rdat, 8'h00);
        chk(errw, 1'b1);
        for (int i = 0; i < 8; i++) begin
            xfer(0, 7'h10, {i[1:0], 6'h00}, 0, 0);
            pkt(i[1], i[0], 2'b00);
        end
        xfer(0, 7'h03, 8'h36, 0, 0);
        crc_on = 1'b1;
        xfer(1, 7'h02, 8'h00, 0, 1);
        chk(rdat, 8'h00);
        chk(rcrc, crc8(24'h0000_00, 2));
        xfer(1, 7'h03, 8'h00, 0, 0);
        chk(rst, 8'h00);
        chk(rcrc, crc8(24'h0036_00, 2));
        xfer(0, 7'h03, 8'h37, 0, 0);
        repeat (100) @(negedge clk);
        xfer(1, 7'h02, 8'h00, 0, 0);
        chk(rdat, 8'h04);
        xfer(0, 7'h10, 8'h00, 1, 0);
        xfer(0, 7'h10, 8'h00, 0, 0);
        xfer(1, 7'h10, 8'h00, 0, 0);
        chk(rdat, 8'hC0);
        chk(rst, 8'h10);
        xfer(0, 7'h01, 8'h10, 0, 0);
        xfer(1, 7'h03, 8'h00, 1, 0);
        chk(rv, 1'b0);
        xfer(1, 7'h03, 8'h00, 0, 0);
        chk(rv, 1'b0);
        xfer(1, 7'h01, 8'h00, 0, 0);
        chk(rdat, 8'h10);
        xfer(0, 7'h01, 8'h10, 0, 0);
        xfer(1, 7'h50, 8'h00, 0, 0);
        chk(rv, 1'b1);
        xfer(1, 7'h51, 8'h00, 0, 0);
        chk(rv, 1'b0);
        xfer(0, 7'h10, 8'h40, 0, 0);
        xfer(1, 7'h10, 8'h00, 0, 0);
        chk({rdat, rst}, 16'hC002);
        xfer(0, 7'h01, 8'h02, 0, 0);
        host.send(32'hA5F0_0000, 12);
        xfer(1, 7'h01, 8'h00, 0, 0);
        chk(rdat, 8'h01);
        xfer(0, 7'h01, 8'h01, 0, 0);
        @(negedge clk) nvm = 1'b1;
        @(negedge clk) nvm = 1'b0;
        xfer(0, 7'h01, 8'h7F, 0, 0);
        xfer(1, 7'h01, 8'h00, 0, 0);
        chk(rdat, 8'h04);
        chk(errw, 1'b0);
        xfer(0, 7'h03, 8'h3F, 0, 0);
        repeat (100) @(negedge clk);
        xfer(1, 7'h01, 8'h00, 0, 0);
        chk(rdat, 8'h0C);
        final_report;
    end
endmodule : adm_monitor_tb
